// file: hw/dtri_map.vh
// Summary of operation
// - Up to 14 processors chain over token ports, forwarding foreign tokens.
// - Node-select number is received during reset and kept for routing.
// - Every arriving token's node-select field is compared with the captured number.
// - Mismatching tokens pass unchanged to the emitter and out the output bus.
// - Matching tokens lose the node-select field and enter the next-hop stage, unless a ring token takes it that cycle.
// - One full ring circuit takes exactly seven pipeline cycles.
// - Next-hop table, operation table and operand memory take one cycle each.
// - Token FIFO and arithmetic stage are two-stage pipelines, two cycles each.
// - Token FIFO spends one cycle writing and one cycle reading.
// - Arithmetic stage spends one cycle executing and one delivering the result.
// - Ring holds seven tokens, one per slot; then it is full.
// - Ring tokens carry a 7-bit arc tag and an 18-bit data field.
// - Arc tag addresses the next-hop table.
// - Each next-hop access replaces the arc tag with the stored tag.
// - Data field is a control bit, a sign bit and 16-bit value.
// - Tokens carry up to two data fields plus opcode and control fields.
// - 32-bit tokens cross a port as two 16-bit halves with request/grant.
// - Intake holds off further tokens while ring slot 4 or 5 holds a token.
`ifndef DTRI_MAP_VH
`define DTRI_MAP_VH
`define DTRI_NODE_HI 31
`define DTRI_NODE_LO 28
`define DTRI_ZBIT 27
`define DTRI_TAG_HI 26
`define DTRI_TAG_LO 20
`define DTRI_CTL_HI 19
`define DTRI_CTL_LO 16
`define DTRI_DAT_HI 15
`define DTRI_DAT_LO 0
`define DTRI_RING_SLOTS 7
`define DTRI_BUSY_CYCLES 2'h2
`endif

// file: hw/dtri_stage.v
`timescale 1ns/1ps
// One ring slot: registered token plus valid bit
module dtri_stage #(
  parameter W = 60
) (
  // Clock and reset
  input wire core_clk,
  input wire sys_rst,
  // Upstream
  input wire in_valid,
  input wire [W-1:0] in_data,
  // Downstream
  output reg out_valid,
  output reg [W-1:0] out_data
);
  always @(posedge core_clk) begin
    if (sys_rst) begin
      out_valid <= 1'b0;
      out_data <= {W{1'b0}};
    end else begin
      out_valid <= in_valid;
      out_data <= in_data;
    end
  end
endmodule

// file: hw/dtri_intake.v
`timescale 1ns/1ps
`include "dtri_map.vh"
module dtri_intake #(
  parameter TAG_W = 7,
  parameter OPSEL_W = 6,
  parameter OPM_AW = 9,
  parameter MAX_NODES = 14
) (
  // Clock and reset
  input wire core_clk,
  input wire sys_rst,
  // Input port
  input wire [15:0] input_word_bus,
  input wire in_request,
  output reg in_grant,
  // Output port
  output reg [15:0] output_word_bus,
  output reg out_request,
  input wire out_grant,
  // Status
  output wire [3:0] node_select_number,
  output wire [2:0] ring_count,
  output wire ring_full
);
  localparam RW = 60;
  localparam SI = 2'h0;
  localparam SH = 2'h1;
  localparam SL = 2'h2;
  localparam SW = 2'h3;

  // Pin synchronisers; stage one is read only by stage two
  reg [15:0] ibus_s1_q, ibus_s2_q;
  reg in_request_s1_q, in_request_s2_q, ogr_s1_q, ogr_s2_q, rst_dly_q;
  always @(posedge core_clk) begin
    ibus_s1_q <= input_word_bus;
    ibus_s2_q <= ibus_s1_q;
    in_request_s1_q <= in_request;
    in_request_s2_q <= in_request_s1_q;
    ogr_s1_q <= out_grant;
    ogr_s2_q <= ogr_s1_q;
    rst_dly_q <= sys_rst;
  end

  // Node select captured at reset release, not under reset
  reg [3:0] node_q;
  always @(posedge core_clk) begin
    if (!sys_rst && rst_dly_q) begin
      node_q <= ibus_s2_q[3:0];
    end
  end
  assign node_select_number = node_q;

  // Ring slots and stage memories
  reg [15:0] next_hop_table [0:(1<<TAG_W)-1];
  reg [39:0] operation_table [0:(1<<OPSEL_W)-1];
  reg [17:0] operand_memory [0:(1<<OPM_AW)-1];
  wire [6:0] sv;
  wire [RW-1:0] sd [0:6];
  reg inj_v;
  reg [RW-1:0] inj_d;
  reg [RW-1:0] nh_d, op_d, om_d, fw_d, ex_d;
  wire ring_v = sv[6];
  wire [RW-1:0] ring_tok = sd[6];
  reg [15:0] nh_ent;
  reg [39:0] op_ent;

  // Slot 0 next-hop, 1 operation, 2 operand, 3-4 FIFO, 5-6 arithmetic
  always @* begin
    nh_ent = next_hop_table[ring_v ? ring_tok[`DTRI_TAG_HI:`DTRI_TAG_LO]
      : inj_d[`DTRI_TAG_HI:`DTRI_TAG_LO]];
    nh_d = ring_v ? ring_tok : inj_d;
    nh_d[`DTRI_TAG_HI:`DTRI_TAG_LO] = nh_ent[12:6];
    nh_d[59:54] = nh_ent[5:0];
    op_ent = operation_table[sd[0][59:54]];
    op_d = sd[0];
    op_d[53:40] = op_ent[39:26];
    om_d = sd[1];
    om_d[39:22] = operand_memory[{2'h0, sd[1][`DTRI_TAG_HI:`DTRI_TAG_LO]}];
    fw_d = sd[3];
    ex_d = sd[5];
    ex_d[14:0] = sd[5][14:0] + sd[5][39:25];
  end

  // Ring traffic wins the next-hop slot; intake injects only into a hole
  wire [6:0] vin = {sv[5], sv[4], sv[3], sv[2], sv[1], sv[0], ring_v | inj_v};
  genvar g;
  generate
    for (g = 0; g < `DTRI_RING_SLOTS; g = g + 1) begin : slot
      wire [RW-1:0] din = (g == 0) ? nh_d : (g == 1) ? op_d : (g == 2) ? om_d :
        (g == 4) ? fw_d : (g == 6) ? ex_d : sd[(g + 6) % 7];
      dtri_stage #(.W(RW)) u_stage (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .in_valid(vin[g]),
        .in_data(din),
        .out_valid(sv[g]),
        .out_data(sd[g])
      );
    end
  endgenerate

  assign ring_count = sv[0] + sv[1] + sv[2] + sv[3] + sv[4] + sv[5] + sv[6];
  assign ring_full = &sv;

  // Busy flag covers slots 4 and 5, two cycles per token
  wire arith_busy = sv[5] | sv[4];

  // Input port: two halves, high then low, four-phase handshake
  reg [1:0] ist_q;
  reg [15:0] hi_q;
  reg [31:0] tok_q;
  reg tok_v_q;
  reg fwd_pend_q;
  reg [31:0] fwd_q;
  reg [1:0] ost_q;
  wire fwd_room = !fwd_pend_q;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      ist_q <= SI;
      in_grant <= 1'b0;
      hi_q <= 16'h0000;
      tok_q <= 32'h0000_0000;
      tok_v_q <= 1'b0;
    end else begin
      tok_v_q <= 1'b0;
      case (ist_q)
        SI: begin
          if (in_request_s2_q && !in_grant && !arith_busy && fwd_room) begin
            hi_q <= ibus_s2_q;
            in_grant <= 1'b1;
            ist_q <= SH;
          end
          if (!in_request_s2_q) begin
            in_grant <= 1'b0;
          end
        end
        SH: begin
          if (!in_request_s2_q) begin
            in_grant <= 1'b0;
            ist_q <= SL;
          end
        end
        SL: begin
          if (in_request_s2_q) begin
            tok_q <= {hi_q, ibus_s2_q};
            in_grant <= 1'b1;
            tok_v_q <= 1'b1;
            ist_q <= SI;
          end
        end
        default: ist_q <= SI;
      endcase
    end
  end

  // Routing decision
  wire is_local = tok_q[`DTRI_NODE_HI:`DTRI_NODE_LO] == node_q;
  always @* begin
    inj_v = tok_v_q && is_local && !ring_v;
    inj_d = {RW{1'b0}};
    inj_d[27:0] = tok_q[`DTRI_ZBIT:0];
  end

  // Lost when ring slot is taken; the local path holds no token over
  // Forward path: single token buffer keeps arrival order
  always @(posedge core_clk) begin
    if (sys_rst) begin
      fwd_pend_q <= 1'b0;
      fwd_q <= 32'h0000_0000;
      ost_q <= SI;
      out_request <= 1'b0;
      output_word_bus <= 16'h0000;
    end else begin
      if (tok_v_q && !is_local) begin
        fwd_q <= tok_q;
        fwd_pend_q <= 1'b1;
      end
      case (ost_q)
        SI: begin
          if (fwd_pend_q && !ogr_s2_q) begin
            output_word_bus <= fwd_q[31:16];
            out_request <= 1'b1;
            ost_q <= SH;
          end
        end
        SH: begin
          if (ogr_s2_q) begin
            out_request <= 1'b0;
            ost_q <= SL;
          end
        end
        SL: begin
          if (!ogr_s2_q) begin
            output_word_bus <= fwd_q[15:0];
            out_request <= 1'b1;
            ost_q <= SW;
          end
        end
        SW: begin
          if (ogr_s2_q) begin
            out_request <= 1'b0;
            fwd_pend_q <= 1'b0;
            ost_q <= SI;
          end
        end
        default: ost_q <= SI;
      endcase
    end
  end

  // Table contents are zeroed at time zero and never written
  integer i;
  initial begin
    for (i = 0; i < (1<<TAG_W); i = i + 1) next_hop_table[i] = 16'h0000;
    for (i = 0; i < (1<<OPSEL_W); i = i + 1) operation_table[i] = 40'h00_0000_0000;
    for (i = 0; i < (1<<OPM_AW); i = i + 1) operand_memory[i] = 18'h0_0000;
  end
endmodule

// file: testbench/dtri_intake_props.sv
`timescale 1ns/1ps
module dtri_intake_props (
  // Clock and reset
  input wire core_clk,
  input wire sys_rst,
  // Watched ports
  input wire in_request,
  input wire in_grant,
  input wire [15:0] output_word_bus,
  input wire out_request,
  input wire out_grant,
  input wire [3:0] node_select_number,
  input wire [2:0] ring_count,
  input wire ring_full
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_out_grant; out_request && out_grant; endsequence
  sequence s_ohalf; out_request ##1 out_request; endsequence
  property p_full; ring_full == (ring_count == 3'h7); endproperty
  a_full: assert property (p_full) else $error("full flag wrong");
  property p_node; !$past(sys_rst) && !$past(sys_rst, 2) |-> $stable(node_select_number); endproperty
  a_node: assert property (p_node) else $error("node number moved");
  property p_grise; $rose(in_grant) |-> in_request; endproperty
  a_grise: assert property (p_grise) else $error("grant without request");
  property p_gfall; $fell(in_grant) |-> !in_request; endproperty
  a_gfall: assert property (p_gfall) else $error("grant dropped early");
  property p_ohold; out_request && !out_grant |=> out_request; endproperty
  a_ohold: assert property (p_ohold) else $error("request withdrawn");
  property p_odata; s_ohalf |-> $stable(output_word_bus); endproperty
  a_odata: assert property (p_odata) else $error("half changed");
  property p_orel; s_out_grant |-> ##[1:4] !out_request; endproperty
  a_orel: assert property (p_orel) else $error("request not released");
  property p_ofall; $fell(out_request) |-> $past(out_grant); endproperty
  a_ofall: assert property (p_ofall) else $error("request fell early");
endmodule
bind dtri_intake dtri_intake_props chk_u (.core_clk(core_clk), .sys_rst(sys_rst),
  .in_request(in_request), .in_grant(in_grant), .output_word_bus(output_word_bus),
  .out_request(out_request), .out_grant(out_grant),
  .node_select_number(node_select_number), .ring_count(ring_count), .ring_full(ring_full));

// file: testbench/dtri_sink.sv
`timescale 1ns/1ps
// Downstream neighbour taking forwarded tokens
module dtri_sink (
  // Clock
  input wire core_clk,
  // Token port
  input wire out_request,
  input wire [15:0] output_word_bus,
  output reg out_grant,
  // Answer delay and capture count
  input wire [3:0] lag,
  output reg [7:0] n_tok
);
  reg [15:0] hi_q;
  reg half_q;
  reg [3:0] cnt_q;
  reg [31:0] got [0:15];
  initial begin
    out_grant = 1'b0;
    n_tok = 8'h00;
    half_q = 1'b0;
    cnt_q = 4'h0;
  end
  // Four-phase per half, high half first
  always @(posedge core_clk) begin
    if (out_request && !out_grant) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q >= lag) begin
        out_grant <= 1'b1;
        cnt_q <= 4'h0;
        half_q <= !half_q;
        hi_q <= output_word_bus;
        if (half_q) begin
          got[n_tok[3:0]] <= {hi_q, output_word_bus};
          n_tok <= n_tok + 8'h01;
        end
      end
    end else if (!out_request && out_grant) begin
      out_grant <= 1'b0;
    end
  end
endmodule

// file: testbench/dtri_intake_bench.sv
`timescale 1ns/1ps
module dtri_intake_bench;
  reg core_clk;
  reg sys_rst;
  reg [15:0] input_word_bus;
  reg in_request;
  reg [3:0] lag;
  wire in_grant, out_request, out_grant, ring_full;
  wire [15:0] output_word_bus;
  wire [3:0] node_select_number;
  wire [2:0] ring_count;
  wire [7:0] n_tok;
  integer num_errors, compares;
  dtri_intake dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .input_word_bus(input_word_bus),
    .in_request(in_request), .in_grant(in_grant), .output_word_bus(output_word_bus),
    .out_request(out_request), .out_grant(out_grant), .node_select_number(node_select_number),
    .ring_count(ring_count), .ring_full(ring_full));
  dtri_sink sink_u (.core_clk(core_clk), .out_request(out_request),
    .output_word_bus(output_word_bus), .out_grant(out_grant), .lag(lag), .n_tok(n_tok));
  task test_done;
    begin
      if (num_errors == 0 && compares > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      compares = compares + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("MISMATCH %0t got %h want %h", $time, g, e);
      end
    end
  endtask
  function [31:0] tk(input [3:0] n);
    tk = {n, 12'h9c3, n, 12'h5a6};
  endfunction
  // Bounded waits, a hang shows as a mismatch
  task wgr(input v);
    integer i;
    begin
      for (i = 0; i < 400 && in_grant !== v; i = i + 1) begin
        @(posedge core_clk);
        #1;
      end
      chk(in_grant, v);
    end
  endtask
  task wtok(input [7:0] n);
    integer i;
    begin
      for (i = 0; i < 3000 && n_tok !== n; i = i + 1) begin
        @(posedge core_clk);
        #1;
      end
      chk(n_tok, n);
    end
  endtask
  task send(input [31:0] t);
    integer h;
    begin
      for (h = 1; h >= 0; h = h - 1) begin
        @(posedge core_clk);
        input_word_bus <= h ? t[31:16] : t[15:0];
        in_request <= 1'b1;
        wgr(1'b1);
        @(posedge core_clk);
        in_request <= 1'b0;
        input_word_bus <= ~input_word_bus;
        wgr(1'b0);
      end
    end
  endtask
  // Node number must stand across release
  task do_rst(input [3:0] nd);
    begin
      @(posedge core_clk);
      sys_rst <= 1'b1;
      input_word_bus <= {12'h000, nd};
      repeat (12) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge core_clk);
      #1;
    end
  endtask
  // Every foreign node, answer lag cycling 0 to 3
  task t_fwd;
    integer j, i;
    begin
      for (j = 0; j < 16; j = j + 1) begin
        lag <= {2'h0, j[1:0]};
        if (j != 5)
          send(tk(j));
      end
      wtok(8'h0f);
      i = 0;
      for (j = 0; j < 16; j = j + 1)
        if (j != 5) begin
          chk(sink_u.got[i], tk(j));
          i = i + 1;
        end
    end
  endtask
  task t_local;
    reg seen;
    begin
      seen = 1'b0;
      send(tk(4'h5));
      repeat (60) begin
        @(posedge core_clk);
        #1;
        if (ring_count !== 3'h0)
          seen = 1'b1;
      end
      chk(seen, 1'b1);
      chk(ring_count, 3'h1);
      chk(ring_full, 1'b0);
      chk(n_tok, 8'h0f);
    end
  endtask
  // Second reset renumbers the node
  task t_renode;
    begin
      do_rst(4'h9);
      chk(node_select_number, 4'h9);
      send(tk(4'h5));
      wtok(8'h10);
      chk(sink_u.got[15], tk(4'h5));
    end
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    #100000;
    num_errors = num_errors + 1;
    test_done;
  end
  initial begin
    num_errors = 0;
    compares = 0;
    lag = 4'h0;
    sys_rst = 1'b1;
    in_request = 1'b0;
    input_word_bus = 16'h0005;
    do_rst(4'h5);
    chk(node_select_number, 4'h5);
    t_fwd;
    t_local;
    t_renode;
    test_done;
  end
endmodule
